/* hdl/lls_top.sv */
// Per-channel loopback, all-ones and de-sync steering of a line interface.
// Assumes pins arrive asynchronously and the framer times its data on
// sys_tx_clock_in, taking a pair on each edge where sys_tx_ready was high.
// Notes on behaviour
// - Digital loopback from pins or host bits.
// - Digital loopback sends transmit stream to receive outputs.
// - Digital loopback keeps line transmit pair silent.
// - Digital loopback ignores the line receive pair.
// - Remote loopback retransmits recovered data, receive timing.
// - Remote loopback still drives receive outputs.
// - Remote with transmit attenuator buffers recovered data.
// - Remote loopback ignores system transmit inputs.
// - All-ones from pin or host bit.
// - All-ones sends alternating marks on line outside digital loop.
// - All-ones pattern timed by transmit clock.
// - Attenuator also offers de-sync smoothing.
// - Mapper feeds gapped data; attenuator smooths it.
// - Three loop modes from two controls.
// - Path select bit places attenuator.
`timescale 1ns/10ps
`include "lls_defines.svh"
module lls_top
  import lls_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sys_tx_clock_in,
  input wire logic sys_tx_pos_rail,
  input wire logic sys_tx_neg_rail,
  output logic sys_tx_ready,
  input wire logic host_mode,
  input wire logic remote_loop_select,
  input wire logic local_loop_select,
  input wire logic send_all_ones,
  input wire logic attenuator_path_select,
  input wire logic remote_loop_bit,
  input wire logic local_loop_bit,
  input wire logic send_all_ones_bit,
  input wire logic attenuator_path_bit,
  input wire logic line_rx_tip,
  input wire logic line_rx_ring,
  output logic line_tx_tip,
  output logic line_tx_ring,
  output logic recovered_rx_clock_out,
  output logic rx_pos_rail_out,
  output logic rx_neg_rail_out
);
  // Core and link state with their next values.
  lls_core_t c_reg;
  lls_core_t c_next;
  lls_link_t l_reg;
  lls_link_t l_next;
  // Synchronised strap pins, line rails and handshake levels.
  logic [3:0] pin_s;
  logic [1:0] line_s;
  logic req_s;
  logic ack_s;
  logic taos_s;
  logic mark_s;
  // Buffer ports.
  logic f_in_v;
  logic f_in_r;
  logic [`LLS_WORD_W-1:0] f_in_d;
  logic f_out_v;
  logic f_pop;
  logic [`LLS_WORD_W-1:0] f_out_d;
  logic [3:0] f_lvl;
  // Steering terms of the current cycle.
  logic remote;
  logic digital;
  logic tx_to_fifo;
  logic rx_to_fifo;
  logic tick;
  logic lnk_new;
  logic rx_done;
  logic tx_load;
  logic ro_load;
  logic ro_src_fifo;
  logic tx_src_fifo;
  logic l_take;
  logic [1:0] l_pair;

  // Strap pins enter the core domain through two flip-flops.
  lls_sync #(.W(4)) u_pin_sync (
    .clk(clk),
    .nrst(nrst),
    .d({remote_loop_select, local_loop_select, send_all_ones, attenuator_path_select}),
    .q(pin_s)
  );
  // Line receive rails enter the core domain the same way.
  lls_sync #(.W(2)) u_line_sync (
    .clk(clk),
    .nrst(nrst),
    .d({line_rx_tip, line_rx_ring}),
    .q(line_s)
  );
  // Word request toggle, link to core.
  lls_sync #(.W(1)) u_req_sync (
    .clk(clk),
    .nrst(nrst),
    .d(l_reg.req),
    .q(req_s)
  );
  // Acknowledge toggle, core to link.
  lls_sync #(.W(1)) u_ack_sync (
    .clk(sys_tx_clock_in),
    .nrst(nrst),
    .d(c_reg.ack),
    .q(ack_s)
  );
  // All-ones level, core to link.
  lls_sync #(.W(1)) u_taos_sync (
    .clk(sys_tx_clock_in),
    .nrst(nrst),
    .d(c_reg.taos),
    .q(taos_s)
  );
  // All-ones mark toggle, link to core; each change is one line mark.
  lls_sync #(.W(1)) u_mark_sync (
    .clk(clk),
    .nrst(nrst),
    .d(l_reg.mark_neg),
    .q(mark_s)
  );

  // Attenuator buffer; it smooths the stream the path select gives it, but always the receive stream in remote loop.
  lls_fifo #(.WIDTH(`LLS_WORD_W), .DEPTH(`LLS_FIFO_DEPTH)) u_ja_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(f_in_v),
    .in_ready(f_in_r),
    .in_data(f_in_d),
    .out_valid(f_out_v),
    .out_ready(f_pop),
    .out_data(f_out_d),
    .level(f_lvl)
  );

  // Link side: gathers dual-rail pairs into words and hands them over.
  always_comb begin
    l_next = l_reg;
    l_pair = {sys_tx_pos_rail, sys_tx_neg_rail};
    if (taos_s) begin
      l_pair = l_reg.mark_neg ? 2'h1 : 2'h2;
    end
    l_take = !l_reg.busy && (taos_s || l_reg.ready);
    if (taos_s) begin
      l_next.mark_neg = !l_reg.mark_neg;
    end
    // A pending word is released once the core echoes the toggle.
    if (l_reg.busy && (ack_s == l_reg.req)) begin
      l_next.busy = 1'b0;
    end
    if (l_take) begin
      l_next.sh = {l_reg.sh[`LLS_WORD_W-3:0], l_pair};
      l_next.cnt = l_reg.cnt + 2'h1;
      if (l_reg.cnt == 2'h3) begin
        l_next.word = {l_reg.sh[`LLS_WORD_W-3:0], l_pair};
        l_next.req = !l_reg.req;
        l_next.busy = 1'b1;
      end
    end
    // Ready stalls the framer while a word waits in the crossing.
    l_next.ready = !l_next.busy && !taos_s;
  end

  // Registers the link state on the system transmit clock.
  always_ff @(posedge sys_tx_clock_in or negedge nrst) begin
    if (!nrst) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  // Steering decode from the registered mode and path select.
  assign remote = (c_reg.mode == LLS_REMOTE);
  assign digital = (c_reg.mode == LLS_DIGITAL);
  assign tx_to_fifo = c_reg.ja_tx && !remote;
  assign rx_to_fifo = !digital && (remote || !c_reg.ja_tx);
  assign tick = (c_reg.tick == 4'(`LLS_SYM_DIV - 1));
  assign lnk_new = (req_s != c_reg.req_seen);
  assign rx_done = tick && !digital && (c_reg.rx_cnt == 2'h3);
  assign f_in_v = tx_to_fifo ? (lnk_new && !remote) : (rx_to_fifo && rx_done);
  assign f_in_d = tx_to_fifo ? l_reg.word : {c_reg.rx_sh[`LLS_WORD_W-3:0], line_s};
  assign tx_src_fifo = remote || tx_to_fifo;
  assign ro_src_fifo = digital ? tx_to_fifo : rx_to_fifo;
  // both remote outputs share each word.
  assign tx_load = tick && (c_reg.tx_n == 3'h0) && !digital &&
                   (!remote || (c_reg.ro_n == 3'h0)) &&
                   (tx_src_fifo ? (f_out_v && c_reg.drain) : c_reg.tx_hold_v);
  assign ro_load = tick && (c_reg.ro_n == 3'h0) &&
                   (!remote || (c_reg.tx_n == 3'h0)) &&
                   (ro_src_fifo ? (f_out_v && c_reg.drain) :
                   (digital ? c_reg.tx_hold_v : c_reg.rx_hold_v));
  assign f_pop = (tx_load && tx_src_fifo) || (ro_load && ro_src_fifo);

  // Core side: mode selection, word hand-over, pacing and the serialisers.
  always_comb begin
    c_next = c_reg;
    c_next.mode = host_mode ? lls_loop_decode(remote_loop_bit, local_loop_bit) :
                  lls_loop_decode(pin_s[3], pin_s[2]);
    c_next.ja_tx = host_mode ? attenuator_path_bit : pin_s[0];
    c_next.taos = host_mode ? send_all_ones_bit : pin_s[1];
    c_next.tick = tick ? 4'h0 : c_reg.tick + 4'h1;
    // A link word is taken once its sink has room; remote discards it.
    if (lnk_new && (remote || (tx_to_fifo ? f_in_r : !c_reg.tx_hold_v))) begin
      c_next.req_seen = req_s;
      c_next.ack = req_s;
      if (!remote && !tx_to_fifo) begin
        c_next.tx_hold = l_reg.word;
        c_next.tx_hold_v = 1'b1;
      end
    end
    if (tick && !digital) begin
      c_next.rx_sh = {c_reg.rx_sh[`LLS_WORD_W-3:0], line_s};
      c_next.rx_cnt = c_reg.rx_cnt + 2'h1;
    end
    // A finished receive word without a buffer slot is an overrun and is lost.
    if (rx_done && !rx_to_fifo && !c_reg.rx_hold_v) begin
      c_next.rx_hold = {c_reg.rx_sh[`LLS_WORD_W-3:0], line_s};
      c_next.rx_hold_v = 1'b1;
    end
    if (f_lvl >= `LLS_JA_START) begin
      c_next.drain = 1'b1;
    end else if (!f_out_v) begin
      c_next.drain = 1'b0;
    end
    if (tx_load) begin
      c_next.tx_sh = tx_src_fifo ? f_out_d : c_reg.tx_hold;
      c_next.tx_n = `LLS_PAIRS;
      if (!tx_src_fifo) begin
        c_next.tx_hold_v = 1'b0;
      end
    end
    if (ro_load) begin
      c_next.ro_sh = ro_src_fifo ? f_out_d : (digital ? c_reg.tx_hold : c_reg.rx_hold);
      c_next.ro_n = `LLS_PAIRS;
      if (!ro_src_fifo && digital) begin
        c_next.tx_hold_v = 1'b0;
      end
      if (!ro_src_fifo && !digital) begin
        c_next.rx_hold_v = 1'b0;
      end
    end
    // The line pair shifts out one symbol per tick, idle spaces otherwise.
    c_next.tip = 1'b0;
    c_next.ring = 1'b0;
    if (tick && (c_next.tx_n != 3'h0)) begin
      c_next.tip = c_next.tx_sh[`LLS_WORD_W-1];
      c_next.ring = c_next.tx_sh[`LLS_WORD_W-2];
      c_next.tx_sh = {c_next.tx_sh[`LLS_WORD_W-3:0], 2'h0};
      c_next.tx_n = c_next.tx_n - 3'h1;
    end
    // marks paced by link clock.
    // In all-ones outside digital loop every change of the synchronised link mark flag puts one mark
    // on the line, so the pattern rate follows sys_tx_clock_in, not the tick.
    c_next.mark_seen = mark_s;
    if (c_reg.taos) begin
      c_next.tip = (mark_s != c_reg.mark_seen) && mark_s;
      c_next.ring = (mark_s != c_reg.mark_seen) && !mark_s;
    end
    if (digital) begin
      c_next.tip = 1'b0;
      c_next.ring = 1'b0;
      c_next.tx_n = 3'h0;
    end
    // The receive pair shifts likewise; its clock pulses with each symbol.
    c_next.rclk = 1'b0;
    if (tick && (c_next.ro_n != 3'h0)) begin
      c_next.rpos = c_next.ro_sh[`LLS_WORD_W-1];
      c_next.rneg = c_next.ro_sh[`LLS_WORD_W-2];
      c_next.ro_sh = {c_next.ro_sh[`LLS_WORD_W-3:0], 2'h0};
      c_next.ro_n = c_next.ro_n - 3'h1;
      c_next.rclk = 1'b1;
    end
  end

  // Registers the core state; every output except sys_tx_ready is taken from it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      c_reg <= '0;
      c_reg.rpos <= `LLS_RST_RAIL;
      c_reg.rneg <= `LLS_RST_RAIL;
    end else begin
      c_reg <= c_next;
    end
  end

  assign line_tx_tip = c_reg.tip;
  assign line_tx_ring = c_reg.ring;
  assign rx_pos_rail_out = c_reg.rpos;
  assign rx_neg_rail_out = c_reg.rneg;
  assign recovered_rx_clock_out = c_reg.rclk;
  assign sys_tx_ready = l_reg.ready;

  // The line stays silent one cycle after digital loopback is in force.
  dlb_line_mute_a: assert property (@(posedge clk) disable iff (!nrst)
    digital |=> !line_tx_tip && !line_tx_ring) else $error("line driven in digital loop");
  // The receive assembler holds still while the line is ignored.
  dlb_rx_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
    digital && $past(digital) |=> $stable(c_reg.rx_cnt)) else $error("line sampled in digital loop");
  // In digital loop the receive outputs carry the transmit stream only.
  dlb_loop_src_a: assert property (@(posedge clk) disable iff (!nrst)
    digital && ro_load |-> f_pop == tx_to_fifo) else $error("receive fed from wrong source");
  // A link word in remote loop is acknowledged and never stored.
  rlb_tx_drop_a: assert property (@(posedge clk) disable iff (!nrst)
    remote && lnk_new |=> c_reg.ack == $past(req_s) && !$rose(c_reg.tx_hold_v))
    else $error("transmit word kept in remote loop");
  // Remote loop loads line and receive outputs from the same buffered word.
  rlb_same_word_a: assert property (@(posedge clk) disable iff (!nrst)
    remote && tx_load && !$past(digital, 2) |-> ro_load) else $error("remote outputs split");
  // The buffer only drains once filled to the start level.
  ja_drain_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(c_reg.drain) |-> $past(f_lvl) >= `LLS_JA_START) else $error("drain started early");
  // All-ones control follows the host bit in host mode.
  taos_select_a: assert property (@(posedge clk) disable iff (!nrst)
    host_mode |=> c_reg.taos == $past(send_all_ones_bit)) else $error("all-ones host source wrong");
  // All-ones control follows the synchronised pin in hardware mode.
  taos_pin_a: assert property (@(posedge clk) disable iff (!nrst)
    !host_mode |=> c_reg.taos == $past(pin_s[1])) else $error("all-ones pin source wrong");
  // Consecutive all-ones symbols alternate between the two rails.
  taos_ami_a: assert property (@(posedge sys_tx_clock_in) disable iff (!nrst)
    taos_s && l_take ##1 taos_s && l_take |=> l_reg.sh[1:0] != $past(l_reg.sh[1:0]) && l_reg.sh[1:0] != 2'h0)
    else $error("all-ones not alternating");
  // The recovered clock is a one-cycle pulse per symbol.
  rclk_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
    recovered_rx_clock_out |=> !recovered_rx_clock_out) else $error("receive clock stuck high");

  cov_digital_c: cover property (@(posedge clk) disable iff (!nrst) digital && ro_load);
  cov_remote_c: cover property (@(posedge clk) disable iff (!nrst) remote && tx_load);
  cov_full_c: cover property (@(posedge clk) disable iff (!nrst) !f_in_r);
  cov_taos_c: cover property (@(posedge sys_tx_clock_in) disable iff (!nrst) taos_s && l_take);
endmodule : lls_top

/* hdl/lls_defines.svh */
// Constants of the loopback and all-ones steering block.
// Assumes a 20 MHz core clock; included by the package and the top module.
`ifndef LLS_DEFINES_SVH
`define LLS_DEFINES_SVH
// Core clock period in nanoseconds.
`define LLS_CLK_NS 50
// Period of one line symbol in nanoseconds.
`define LLS_SYM_NS 100
// Core clock cycles per line symbol, a least time rounded up.
`define LLS_SYM_DIV ((`LLS_SYM_NS + `LLS_CLK_NS - 1) / `LLS_CLK_NS)
// Width of a word of four dual-rail symbol pairs.
`define LLS_WORD_W 8
// Symbol pairs in one word.
`define LLS_PAIRS 3'h4
// Words held by the attenuator buffer.
`define LLS_FIFO_DEPTH 8
// Fill level at which the attenuator starts to drain at a steady rate.
`define LLS_JA_START 4'h4
// Reset value of the receive rail outputs.
`define LLS_RST_RAIL 1'b0
`endif

/* hdl/lls_pkg.sv */
// Types shared by the loopback and all-ones steering block.
// Assumes the defines header sits beside it.
`include "lls_defines.svh"
package lls_pkg;
  // Loop modes selected by the remote and local loop controls.
  typedef enum logic [1:0] {LLS_NORMAL, LLS_ANALOG, LLS_REMOTE, LLS_DIGITAL} lls_loop_t;

  // Core-domain state.
  typedef struct packed {
    lls_loop_t mode;
    logic ja_tx;
    logic taos;
    logic req_seen;
    logic ack;
    logic [`LLS_WORD_W-1:0] tx_hold;
    logic tx_hold_v;
    logic [`LLS_WORD_W-1:0] rx_sh;
    logic [1:0] rx_cnt;
    logic [`LLS_WORD_W-1:0] rx_hold;
    logic rx_hold_v;
    logic [3:0] tick;
    logic [`LLS_WORD_W-1:0] tx_sh;
    logic [2:0] tx_n;
    logic [`LLS_WORD_W-1:0] ro_sh;
    logic [2:0] ro_n;
    logic drain;
    logic tip;
    logic ring;
    logic rpos;
    logic rneg;
    logic rclk;
    logic mark_seen;
  } lls_core_t;

  // Link-domain state, clocked by the system transmit clock.
  typedef struct packed {
    logic [`LLS_WORD_W-1:0] sh;
    logic [1:0] cnt;
    logic [`LLS_WORD_W-1:0] word;
    logic req;
    logic busy;
    logic ready;
    logic mark_neg;
  } lls_link_t;

  // Maps the remote and local loop controls onto a loop mode.
  function automatic lls_loop_t lls_loop_decode(input logic rlb, input logic llb);
    case ({rlb, llb})
      2'h1: lls_loop_decode = LLS_ANALOG;
      2'h2: lls_loop_decode = LLS_REMOTE;
      2'h3: lls_loop_decode = LLS_DIGITAL;
      default: lls_loop_decode = LLS_NORMAL;
    endcase
  endfunction : lls_loop_decode
endpackage : lls_pkg

/* hdl/lls_sync.sv */
// Two-stage synchroniser for levels entering a clock domain.
// Assumes each bit is a level that stays put for several clock periods.
`timescale 1ns/10ps
module lls_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // Both stages; the first is read only by the second.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lls_sync_t;
  lls_sync_t st_reg;
  lls_sync_t st_next;

  // Shifts the input through the two stages.
  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  // Registers the stages; reset clears both.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule : lls_sync

/* hdl/lls_fifo.sv */
// Word buffer of the jitter attenuator, with valid and ready on both sides.
// Assumes one clock; the drain side may stall so the buffer really fills.
`timescale 1ns/10ps
module lls_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [3:0] level
);
  localparam int AW = $clog2(DEPTH);
  // Storage, pointers and fill count in one state word.
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } lls_fifo_t;
  lls_fifo_t st_reg;
  lls_fifo_t st_next;
  logic push;
  logic pop;

  assign in_ready = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data = st_reg.mem[st_reg.rd];
  assign level = 4'(st_reg.cnt);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Writes at the write pointer, reads at the read pointer, tracks the count.
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data;
      st_next.wr = AW'((st_reg.wr + 1'b1) % DEPTH);
    end
    if (pop) begin
      st_next.rd = AW'((st_reg.rd + 1'b1) % DEPTH);
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Registers the buffer state.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Full is honest: refusal only when every slot holds a word.
  fifo_full_a: assert property (@(posedge clk) disable iff (!nrst)
    !in_ready |-> st_reg.cnt == (AW+1)'(DEPTH)) else $error("buffer refused while not full");
endmodule : lls_fifo

/* tb/lls_framer_model.sv */
// Framer model on the system side of the steering block.
// Assumes the bench gives a free 80 ns source clock and a cumulative word target.
`timescale 1ns/10ps
module lls_framer_model (
  input wire logic link_src,
  input wire logic nrst,
  input wire logic ready,
  input wire logic free_run,
  input wire logic [7:0] word,
  input int target,
  output logic link_clk,
  output logic pos,
  output logic neg,
  output int sent
);
  // Clock gate, moved only while the source is low so no pulse is clipped.
  logic run = 1'b0;
  // Index of the pair now on the rails.
  logic [1:0] idx;

  always @(negedge link_src) begin
    run <= free_run || (sent < target);
  end
  assign link_clk = link_src & run;

  // A pair counts as taken only at an edge where ready was high.
  always @(posedge link_clk) begin
    if (!nrst) begin
      idx <= 2'h0;
      sent <= 0;
    end else if (ready) begin
      idx <= idx + 2'h1;
      if (idx == 2'h3) begin
        sent <= sent + 1;
      end
    end
  end

  always @(posedge link_clk) begin
    #1;
    if (!nrst) begin
      {pos, neg} = 2'h0;
    end else if (sent < target) begin
      {pos, neg} = word[7 - 2 * idx -: 2];
    end else begin
      // Released rails show the inverse, so stale data is never mistaken for good.
      {pos, neg} = ~{pos, neg};
    end
  end

  // Rails start at a known level before the first clock.
  initial begin
    pos = 1'b0;
    neg = 1'b0;
  end
endmodule : lls_framer_model

/* tb/tb_lls_top.sv */
// Self-checking bench of the loopback and all-ones steering block.
// Assumes the framer model beside it and a line receive driver in this file.
`timescale 1ns/10ps
module tb_lls_top;
  logic clk = 1'b0;
  logic link_src = 1'b0;
  logic nrst = 1'b0;
  logic hm = 1'b0;
  logic [3:0] pin = 4'h0;
  logic [3:0] hb = 4'h0;
  logic [1:0] rx_sel = 2'h1;
  logic rx_ph = 1'b0;
  logic rtip = 1'b0;
  logic rring = 1'b0;
  logic free_run = 1'b1;
  logic [7:0] word = 8'h99;
  int target = 0;
  logic link_clk, pos, neg, ready, tip, ring, rclk, rpos, rneg;
  int sent, tx_evt, tx_bad, rx_evt, rx_bad, fails, comparisons;
  logic [1:0] tx_prev, tx_last, rx_last, tx_first, rx_first;

  // Core clock of 50 ns and an unrelated link source of 80 ns.
  always #25 clk = ~clk;
  always #40 link_src = ~link_src;

  lls_framer_model framer_u (.link_src(link_src), .nrst(nrst), .ready(ready), .free_run(free_run),
    .word(word), .target(target), .link_clk(link_clk), .pos(pos), .neg(neg), .sent(sent));

  lls_top dut_u (.clk(clk), .nrst(nrst), .sys_tx_clock_in(link_clk), .sys_tx_pos_rail(pos),
    .sys_tx_neg_rail(neg), .sys_tx_ready(ready), .host_mode(hm), .remote_loop_select(pin[3]),
    .local_loop_select(pin[2]), .send_all_ones(pin[1]), .attenuator_path_select(pin[0]),
    .remote_loop_bit(hb[3]), .local_loop_bit(hb[2]), .send_all_ones_bit(hb[1]),
    .attenuator_path_bit(hb[0]), .line_rx_tip(rtip), .line_rx_ring(rring), .line_tx_tip(tip),
    .line_tx_ring(ring), .recovered_rx_clock_out(rclk), .rx_pos_rail_out(rpos), .rx_neg_rail_out(rneg));

  // Line receive pair: one symbol per 100 ns, quiet, alternating marks or stuck at 11.
  always @(posedge clk) begin
    #1;
    rx_ph = ~rx_ph;
    if (rx_ph) begin
      {rtip, rring} = (rx_sel == 2'h1) ? (rtip ? 2'h1 : 2'h2) : (rx_sel == 2'h2 ? 2'h3 : 2'h0);
    end
  end

  // Counts new marks on both outputs and flags a repeated or doubled mark.
  always @(posedge clk) begin
    tx_prev <= {tip, ring};
    if ({tip, ring} !== 2'h0 && {tip, ring} !== tx_prev) begin
      if (tx_evt == 0) tx_first <= {tip, ring};
      if ({tip, ring} === 2'h3 || {tip, ring} === tx_last) tx_bad <= tx_bad + 1;
      tx_last <= {tip, ring};
      tx_evt <= tx_evt + 1;
    end
    if (rclk === 1'b1) begin
      if (rx_evt == 0) rx_first <= {rpos, rneg};
      if ({rpos, rneg} === 2'h3 || {rpos, rneg} === rx_last) rx_bad <= rx_bad + 1;
      rx_last <= {rpos, rneg};
      rx_evt <= rx_evt + 1;
    end
  end

  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Compares a seen value with the expected one.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Waits whole core cycles and steps just past the edge.
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk

  // Clears the output monitors.
  task automatic clr();
    tx_evt = 0;
    tx_bad = 0;
    rx_evt = 0;
    rx_bad = 0;
    tx_last = 2'h0;
    rx_last = 2'h0;
  endtask : clr

  // Sets controls {remote, local, all-ones, path} from host bits or from pins.
  task automatic ctl(input logic h, input logic [3:0] c);
    hm = h;
    hb = h ? c : 4'h0;
    pin = h ? 4'h0 : c;
    wait_clk(8);
  endtask : ctl

  // Has the framer send n words, with a bounded wait.
  task automatic send(input int n);
    int k;
    k = 0;
    target = target + n;
    while (sent < target && k < 400) begin
      @(posedge clk);
      k++;
    end
    #1;
    if (k >= 400) begin
      fails++;
      print_verdict();
    end
  endtask : send

  // Attenuator in transmit path holds back until four words are in.
  task automatic s_atten();
    ctl(1'b1, 4'h1);
    rx_sel = 2'h0;
    clr();
    send(3);
    wait_clk(30);
    check("ja_hold", tx_evt, 0);
    send(1);
    wait_clk(50);
    check("ja_marks", tx_evt, 16);
    check("ja_first", tx_first, 2'h2);
    check("ja_bad", tx_bad, 0);
  endtask : s_atten

  // Plain path from framer to line and from line to receive outputs.
  task automatic s_normal();
    ctl(1'b1, 4'h0);
    rx_sel = 2'h1;
    wait_clk(64);
    clr();
    send(2);
    wait_clk(20);
    check("nrm_tx", tx_evt, 8);
    check("nrm_first", tx_first, 2'h2);
    check("nrm_rx", rx_evt > 0, 1);
    check("nrm_rxbad", rx_bad, 0);
  endtask : s_normal

  // Digital loop chosen by pins, with garbage on the line receive pair.
  task automatic s_digital();
    ctl(1'b0, 4'hC);
    rx_sel = 2'h2;
    wait_clk(10);
    clr();
    send(2);
    wait_clk(20);
    check("dig_rx", rx_evt, 8);
    check("dig_first", rx_first, 2'h2);
    check("dig_rxbad", rx_bad, 0);
    check("dig_tx", tx_evt, 0);
  endtask : s_digital

  // Remote loop while the framer keeps pushing junk.
  task automatic s_remote();
    rx_sel = 2'h1;
    wait_clk(4);
    ctl(1'b1, 4'h8);
    free_run = 1'b1;
    wait_clk(60);
    clr();
    wait_clk(40);
    free_run = 1'b0;
    check("rem_tx", tx_evt >= 16, 1);
    check("rem_txbad", tx_bad, 0);
    check("rem_rx", rx_evt >= 16, 1);
    check("rem_rxbad", rx_bad, 0);
    wait_clk(6);
    target = sent;
  endtask : s_remote

  // All-ones from pin and then from host bit, one mark per link edge.
  task automatic s_all_ones();
    for (int k = 0; k < 2; k++) begin
      ctl(k[0], 4'h2);
      free_run = 1'b1;
      wait_clk(10);
      clr();
      wait_clk(40);
      check("aos_ready", ready, 1'b0);
      check("aos_rate", tx_evt >= 23 && tx_evt <= 27, 1);
      check("aos_bad", tx_bad, 0);
      ctl(k[0], 4'h0);
      free_run = 1'b0;
      wait_clk(6);
      target = sent;
    end
  endtask : s_all_ones

  // Main sequence: reset with the link clock running, then each scenario.
  initial begin
    wait_clk(8);
    nrst = 1'b1;
    free_run = 1'b0;
    wait_clk(6);
    target = sent;
    s_atten();
    s_normal();
    s_digital();
    s_remote();
    s_all_ones();
    print_verdict();
  end
endmodule : tb_lls_top
